// ===== design/ssc_pkg.sv
`default_nettype none
package ssc_pkg;
  localparam int ADDR_W_DEF  = 17;
  localparam int DATA_W_DEF  = 36;
  localparam int BYTES_DEF   = 4;
  localparam int BURST_W     = 2;
  localparam logic BURST_LINEAR      = 1'b0;
  localparam logic BURST_INTERLEAVED = 1'b1;
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;
  localparam logic [1:0] SYNC_RESET  = 2'h0;
  localparam logic [1:0] SYNC_IDLE_N = 2'h3;
  typedef enum {SSC_IDLE, SSC_READ, SSC_WRITE} ssc_op_t;
endpackage
`default_nettype wire

// ===== design/ssc_burst_if.sv
`default_nettype none
interface ssc_burst_if;
  import ssc_pkg::*;
  logic               mode;
  logic [BURST_W-1:0] base_low;
  logic [BURST_W-1:0] step;
  logic [BURST_W-1:0] addr_low;
  modport gen  (input mode, input base_low, input step, output addr_low);
  modport user (output mode, output base_low, output step, input addr_low);
endinterface
`default_nettype wire

// ===== design/ssc_burst_gen.sv
`default_nettype none
module ssc_burst_gen
  import ssc_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  ssc_burst_if.gen    burst
);
  // Linear order adds the step, interleaved order flips bits of the start
  always_comb begin
    if (burst.mode == BURST_LINEAR) begin
      burst.addr_low = burst.base_low + burst.step;
    end else begin
      burst.addr_low = burst.base_low ^ burst.step;
    end
  end

  a_burst_linear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (burst.mode == BURST_LINEAR && burst.step == BURST_STEP)
      |-> burst.addr_low == BURST_W'(burst.base_low + BURST_STEP))
    else $error("linear burst order wrong");
  a_burst_inter: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (burst.mode == BURST_INTERLEAVED) |-> burst.addr_low == (burst.base_low ^ burst.step))
    else $error("interleaved burst order wrong");
endmodule
`default_nettype wire

// ===== design/ssc_sram.sv
// Functional notes
// - Selected only with select a low, select b high, select c low.
// - Burst order input 0 gives linear, 1 gives interleaved order.
// - A cycle with clock qualify high is ignored; no array write happens.
// - After sleep the data pins stay undriven until a later read.
`default_nettype none
module ssc_sram
  import ssc_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int DATA_W = DATA_W_DEF,
  parameter int BYTES  = BYTES_DEF
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              adv_ld_in,
  input  wire logic              we_n_in,
  input  wire logic [BYTES-1:0]  bw_n_in,
  input  wire logic              chip_select_low_a_in,
  input  wire logic              chip_select_high_b_in,
  input  wire logic              chip_select_low_c_in,
  input  wire logic              clock_qualify_n_in,
  input  wire logic              burst_mode_in,
  input  wire logic              sleep_request_in,
  input  wire logic              oe_n_in,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_out
);
  localparam int LANE_W = DATA_W / BYTES;
  localparam int DEPTH  = 1 << ADDR_W;

  logic [DATA_W-1:0] mem [DEPTH];

  logic [1:0]        sleep_sync;
  logic [1:0]        oe_n_sync;
  ssc_op_t           op;
  ssc_op_t           next_op;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic [BURST_W-1:0] cnt;
  logic [BURST_W-1:0] next_cnt;
  logic              wr_pend;
  logic              next_wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [BYTES-1:0]  wr_bw_n;
  logic [BYTES-1:0]  next_wr_bw_n;
  logic [DATA_W-1:0] next_dq;
  logic              next_dq_oe;
  logic              selected;
  logic              stalled;
  logic              asleep;
  logic              access;
  logic              mem_we;
  logic [ADDR_W-1:0] eff_addr;
  ssc_op_t           cyc_op;

  ssc_burst_if burst ();

  ssc_burst_gen u_burst (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .burst    (burst.gen)
  );

  // Asynchronous pins pass two flops before use
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_sync <= SYNC_RESET;
      oe_n_sync  <= SYNC_IDLE_N;
    end else begin
      sleep_sync <= {sleep_sync[0], sleep_request_in};
      oe_n_sync  <= {oe_n_sync[0], oe_n_in};
    end
  end

  assign selected = !chip_select_low_a_in && chip_select_high_b_in
                    && !chip_select_low_c_in;
  assign stalled  = clock_qualify_n_in;
  assign asleep   = sleep_sync[1];

  assign burst.mode     = burst_mode_in;
  assign burst.base_low = base[BURST_W-1:0];
  assign burst.step     = cnt + BURST_STEP;

  always_comb begin
    next_op      = op;
    next_base    = base;
    next_cnt     = cnt;
    next_wr_pend = wr_pend;
    next_wr_addr = wr_addr;
    next_wr_bw_n = wr_bw_n;
    next_dq      = dq_out;
    next_dq_oe   = dq_oe_out;
    mem_we       = 1'b0;
    cyc_op       = SSC_IDLE;
    eff_addr     = base;
    access       = 1'b0;
    if (asleep) begin
      next_op      = SSC_IDLE;
      next_wr_pend = 1'b0;
      next_dq_oe   = 1'b0;
    end else if (!stalled) begin
      mem_we       = wr_pend;
      next_wr_pend = 1'b0;
      if (!adv_ld_in) begin
        next_cnt  = BURST_FIRST;
        next_base = addr_in;
        eff_addr  = addr_in;
        if (selected) begin
          cyc_op = we_n_in ? SSC_READ : SSC_WRITE;
        end
        next_op = cyc_op;
      end else begin
        next_cnt = burst.step;
        eff_addr = {base[ADDR_W-1:BURST_W], burst.addr_low};
        cyc_op   = op;
        if (op == SSC_WRITE) begin
          next_wr_bw_n = bw_n_in;
        end
      end
      access = (cyc_op != SSC_IDLE);
      if (cyc_op == SSC_WRITE) begin
        next_wr_pend = 1'b1;
        next_wr_addr = eff_addr;
        next_wr_bw_n = bw_n_in;
      end
      // Flow-through read data and output drive follow the taken command
      next_dq_oe = (cyc_op == SSC_READ) && !oe_n_sync[1];
      if (cyc_op == SSC_READ) begin
        next_dq = mem[eff_addr];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op        <= SSC_IDLE;
      base      <= '0;
      cnt       <= BURST_FIRST;
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
      wr_bw_n   <= '1;
      dq_out    <= '0;
      dq_oe_out <= 1'b0;
    end else begin
      op        <= next_op;
      base      <= next_base;
      cnt       <= next_cnt;
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      wr_bw_n   <= next_wr_bw_n;
      dq_out    <= next_dq;
      dq_oe_out <= next_dq_oe;
    end
  end

  // Array write one cycle after the write command, per byte lane
  always_ff @(posedge clk_in) begin
    for (int b = 0; b < BYTES; b++) begin
      if (mem_we && !wr_bw_n[b]) begin
        mem[wr_addr][b*LANE_W +: LANE_W] <= dq_in[b*LANE_W +: LANE_W];
      end
    end
  end

  a_select_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!asleep && !stalled && !adv_ld_in && !selected) |=> !dq_oe_out && !wr_pend)
    else $error("deselected load started an access");
  a_stall_nowrite: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    stalled |-> !mem_we)
    else $error("array written in a stalled cycle");
  a_stall_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (stalled && !asleep) |=> $stable(dq_out) && $stable(dq_oe_out) && $stable(wr_pend))
    else $error("state changed in a stalled cycle");
  a_sleep_hiz: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    asleep ##1 !asleep |-> !dq_oe_out)
    else $error("data pins driven on sleep exit");
  a_wake_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!asleep && !stalled && !adv_ld_in && selected && we_n_in && !oe_n_sync[1])
      |=> dq_oe_out && dq_out == $past(mem[addr_in]))
    else $error("read not served while awake");
  a_wake_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!asleep && !stalled && !adv_ld_in && selected && !we_n_in)
      |=> wr_pend && wr_addr == $past(addr_in) && !dq_oe_out)
    else $error("write not taken while awake");

  // Sleep, stall and burst bookkeeping
  a_sleep_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    asleep |=> !dq_oe_out && !wr_pend)
    else $error("pins driven or write kept while asleep");
  a_wake_undriven: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!asleep && !access && !dq_oe_out) |=> !dq_oe_out)
    else $error("data pins driven without a read");
  a_deselect_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!asleep && !stalled && !adv_ld_in && !selected) |-> !access)
    else $error("deselected load counted as an access");
  a_stall_state: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (stalled && !asleep) |=> $stable(op) && $stable(base) && $stable(cnt))
    else $error("command state changed in a stalled cycle");
  a_stall_wrkeep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (stalled && !asleep) |=> $stable(wr_addr) && $stable(wr_bw_n))
    else $error("pending write changed in a stalled cycle");
  a_load_first: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!asleep && !stalled && !adv_ld_in) |=> cnt == BURST_FIRST && base == $past(addr_in))
    else $error("load did not restart the burst");
  a_burst_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!asleep && !stalled && adv_ld_in) |=> cnt == BURST_W'($past(cnt) + BURST_STEP))
    else $error("burst count did not advance");
  a_adv_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!asleep && !stalled && adv_ld_in && op == SSC_READ && !oe_n_sync[1]) |=> dq_oe_out)
    else $error("burst read not driven while awake");
  a_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!asleep && !stalled && wr_pend) |-> mem_we)
    else $error("pending write not written while awake");
endmodule
`default_nettype wire

// ===== test/ssc_ctrl_model.sv
`default_nettype none
module ssc_ctrl_model (
  input  wire logic   clk_in,
  output logic [3:0]  addr_out,
  output logic        adv_ld_out,
  output logic        we_n_out,
  output logic [2:0]  sel_out,
  output logic        qual_n_out,
  output logic        sleep_out,
  output logic [35:0] dq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // One command per edge, changed 1 ns after the edge
  task automatic cmd(input logic [3:0] a, input logic adv, input logic we,
                     input logic [2:0] s, input logic q, input logic [35:0] d);
    addr_out = a;
    adv_ld_out = adv;
    we_n_out = we;
    sel_out = s;
    qual_n_out = q;
    dq_out = d;
    @(posedge clk_in);
    #1;
  endtask
  // Deselect first, then change the sleep request
  task automatic nap(input logic on);
    cmd(4'h0, 1'b0, 1'b1, 3'b100, 1'b0, ~dq_out);
    sleep_out = on;
  endtask
  initial begin
    addr_out = 4'h0;
    adv_ld_out = 1'b0;
    we_n_out = 1'b1;
    sel_out = 3'b100;
    qual_n_out = 1'b0;
    sleep_out = 1'b0;
    dq_out = 36'h0;
  end
endmodule
`default_nettype wire

// ===== test/sync_sram_control_notes_bench.sv
`default_nettype none
module sync_sram_control_notes_bench
  import ssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_n, adv, we_n, qn, mode, sleep, oe;
  logic [3:0]  addr;
  logic [2:0]  sel;
  logic [35:0] dq_w, dq_r;
  int          bad_count, comparisons, cycles;
  ssc_ctrl_model u_ctl (.clk_in(clk), .addr_out(addr), .adv_ld_out(adv), .we_n_out(we_n),
    .sel_out(sel), .qual_n_out(qn), .sleep_out(sleep), .dq_out(dq_w));
  ssc_sram #(.ADDR_W(4)) u_dut (.clk_in(clk), .rst_n_in(rst_n), .addr_in(addr),
    .adv_ld_in(adv), .we_n_in(we_n), .bw_n_in(4'h0), .chip_select_low_a_in(sel[2]),
    .chip_select_high_b_in(sel[1]), .chip_select_low_c_in(sel[0]),
    .clock_qualify_n_in(qn), .burst_mode_in(mode), .sleep_request_in(sleep),
    .oe_n_in(1'b0), .dq_in(dq_w), .dq_out(dq_r), .dq_oe_out(oe));
  function automatic logic [35:0] pat(input logic [3:0] a);
    return {4'h5, 28'h0, a};
  endfunction
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle();
    u_ctl.cmd(4'h0, 1'b0, 1'b1, 3'b100, 1'b0, ~dq_w);
  endtask
  task automatic wr(input logic [3:0] a, input logic [35:0] d);
    u_ctl.cmd(a, 1'b0, 1'b0, 3'b010, 1'b0, ~d);
    u_ctl.cmd(4'h0, 1'b0, 1'b1, 3'b100, 1'b0, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [35:0] exp);
    u_ctl.cmd(a, 1'b0, 1'b1, 3'b010, 1'b0, ~dq_w);
    check({35'h0, oe}, 36'h1);
    check(dq_r, exp);
  endtask
  task automatic t_select();
    for (int i = 0; i < 8; i++) begin
      u_ctl.cmd(4'h5, 1'b0, 1'b1, i[2:0], 1'b0, ~dq_w);
      check({35'h0, oe}, {35'h0, i == 2});
    end
    $display("test select done");
  endtask
  task automatic t_burst();
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      idle();
      rd(4'h9, pat(4'h9));
      for (int s = 1; s < 4; s++) begin
        u_ctl.cmd(4'h0, 1'b1, 1'b1, 3'b010, 1'b0, ~dq_w);
        check(dq_r, pat(m ? 4'h9 ^ s[3:0] : {2'b10, 2'(1 + s)}));
      end
    end
    $display("test burst done");
  endtask
  task automatic t_stall();
    u_ctl.cmd(4'h6, 1'b0, 1'b0, 3'b010, 1'b1, 36'h0);
    u_ctl.cmd(4'h0, 1'b0, 1'b1, 3'b100, 1'b0, 36'h0);
    rd(4'h6, pat(4'h6));
    u_ctl.cmd(4'h0, 1'b0, 1'b1, 3'b100, 1'b1, ~dq_w);
    check(dq_r, pat(4'h6));
    $display("test stall done");
  endtask
  task automatic t_sleep();
    u_ctl.nap(1'b1);
    repeat (3) idle();
    wr(4'h7, 36'h0);
    u_ctl.cmd(4'h7, 1'b0, 1'b1, 3'b010, 1'b0, ~dq_w);
    check({35'h0, oe}, 36'h0);
    u_ctl.nap(1'b0);
    repeat (3) idle();
    check({35'h0, oe}, 36'h0);
    rd(4'h7, pat(4'h7));
    $display("test sleep done");
  endtask
  task automatic end_of_test();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    mode = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) idle();
    for (int a = 0; a < 16; a++) wr(a[3:0], pat(a[3:0]));
    t_select();
    t_burst();
    t_stall();
    t_sleep();
    end_of_test();
  end
endmodule
`default_nettype wire
